// file: rtl/ddrc_top.sv
/*
 * control and data registers for two voltage-output converters.
 * assumes the core issues single-cycle sfr read and write strobes on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module ddrc_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire ddrc_pkg::ddrc_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    output var ddrc_pkg::ddrc_chan_out_s ch0_out,
    output var ddrc_pkg::ddrc_chan_out_s ch1_out
);
    import ddrc_pkg::*;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] ch0_low;
        logic [7:0] ch0_high;
        logic [7:0] ch1_low;
        logic [7:0] ch1_high;
        logic [DDRC_CODE_W-1:0] ch0_code;
        logic [DDRC_CODE_W-1:0] ch1_code;
        logic [7:0] rdata;
    } ddrc_state_s;

    ddrc_state_s state_q;
    ddrc_state_s state_d;
    logic [DDRC_CODE_W-1:0] ch0_pending;
    logic [DDRC_CODE_W-1:0] ch1_pending;
    logic [DDRC_CODE_W-1:0] ch0_new;
    logic [DDRC_CODE_W-1:0] ch1_new;
    logic [7:0] next_control;

    // =========================================================
    // new codes from the bytes as they will stand after this cycle, pending codes from the stored bytes
    logic [7:0] ch0_low_n;
    logic [7:0] ch0_high_n;
    logic [7:0] ch1_low_n;
    logic [7:0] ch1_high_n;

    ddrc_code_form u_form0 (
        .mode8(next_control[DDRC_BIT_MODE8]),
        .data_low(ch0_low_n),
        .data_high(ch0_high_n),
        .code(ch0_new)
    );
    ddrc_code_form u_form1 (
        .mode8(next_control[DDRC_BIT_MODE8]),
        .data_low(ch1_low_n),
        .data_high(ch1_high_n),
        .code(ch1_new)
    );
    ddrc_code_form u_form0p (
        .mode8(state_q.control[DDRC_BIT_MODE8]),
        .data_low(state_q.ch0_low),
        .data_high(state_q.ch0_high),
        .code(ch0_pending)
    );
    ddrc_code_form u_form1p (
        .mode8(state_q.control[DDRC_BIT_MODE8]),
        .data_low(state_q.ch1_low),
        .data_high(state_q.ch1_high),
        .code(ch1_pending)
    );

    // =========================================================
    // register writes, reads and output update
    always_comb begin
        logic wr_c;
        logic wr_l0;
        logic wr_h0;
        logic wr_l1;
        logic wr_h1;
        logic sync_rise;
        wr_c = sfr_req.wr && (sfr_req.addr == DDRC_ADDR_CONTROL);
        wr_l0 = sfr_req.wr && (sfr_req.addr == DDRC_ADDR_CH0_LOW);
        wr_h0 = sfr_req.wr && (sfr_req.addr == DDRC_ADDR_CH0_HIGH);
        wr_l1 = sfr_req.wr && (sfr_req.addr == DDRC_ADDR_CH1_LOW);
        wr_h1 = sfr_req.wr && (sfr_req.addr == DDRC_ADDR_CH1_HIGH);
        state_d = state_q;
        next_control = wr_c ? sfr_req.wdata : state_q.control;
        ch0_low_n = wr_l0 ? sfr_req.wdata : state_q.ch0_low;
        ch0_high_n = wr_h0 ? sfr_req.wdata : state_q.ch0_high;
        ch1_low_n = wr_l1 ? sfr_req.wdata : state_q.ch1_low;
        ch1_high_n = wr_h1 ? sfr_req.wdata : state_q.ch1_high;
        state_d.control = next_control;
        state_d.ch0_low = ch0_low_n;
        state_d.ch0_high = ch0_high_n;
        state_d.ch1_low = ch1_low_n;
        state_d.ch1_high = ch1_high_n;
        sync_rise = wr_c && !state_q.control[DDRC_BIT_SYNC] && sfr_req.wdata[DDRC_BIT_SYNC];
        // immediate mode: a low-byte write loads that channel only
        if (state_q.control[DDRC_BIT_SYNC] && wr_l0) begin
            state_d.ch0_code = ch0_new;
        end
        if (state_q.control[DDRC_BIT_SYNC] && wr_l1) begin
            state_d.ch1_code = ch1_new;
        end
        // held mode: setting sync loads both channels together
        if (sync_rise) begin
            state_d.ch0_code = ch0_pending;
            state_d.ch1_code = ch1_pending;
        end
        state_d.rdata = state_q.rdata;
        if (sfr_req.rd) begin
            unique case (sfr_req.addr)
                DDRC_ADDR_CH0_LOW: state_d.rdata = state_q.ch0_low;
                DDRC_ADDR_CH0_HIGH: state_d.rdata = state_q.ch0_high;
                DDRC_ADDR_CH1_LOW: state_d.rdata = state_q.ch1_low;
                DDRC_ADDR_CH1_HIGH: state_d.rdata = state_q.ch1_high;
                DDRC_ADDR_CONTROL: state_d.rdata = state_q.control;
                default: state_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q.control <= DDRC_CONTROL_RESET;
            state_q.ch0_low <= DDRC_DATA_RESET;
            state_q.ch0_high <= DDRC_DATA_RESET;
            state_q.ch1_low <= DDRC_DATA_RESET;
            state_q.ch1_high <= DDRC_DATA_RESET;
            state_q.ch0_code <= '0;
            state_q.ch1_code <= '0;
            state_q.rdata <= 8'h00;
        end else begin
            state_q <= state_d;
        end
    end

    // =========================================================
    // decode and outputs
    always_comb begin
        sfr_hit = (sfr_req.addr >= DDRC_ADDR_CH0_LOW) && (sfr_req.addr <= DDRC_ADDR_CONTROL);
    end
    assign sfr_rdata = state_q.rdata;

    ddrc_chan_drive u_drive0 (
        .latched_code(state_q.ch0_code),
        .clear_n(state_q.control[DDRC_BIT_CH0_OUTPUT_CLEAR_N]),
        .power_on(state_q.control[DDRC_BIT_PD0]),
        .range_supply(state_q.control[DDRC_BIT_CH0_RANGE_SELECT]),
        .chan(ch0_out)
    );
    ddrc_chan_drive u_drive1 (
        .latched_code(state_q.ch1_code),
        .clear_n(state_q.control[DDRC_BIT_CH1_OUTPUT_CLEAR_N]),
        .power_on(state_q.control[DDRC_BIT_PD1]),
        .range_supply(state_q.control[DDRC_BIT_CH1_RANGE_SELECT]),
        .chan(ch1_out)
    );
endmodule
`default_nettype wire

// file: rtl/ddrc_pkg.sv
/*
 * constants and carriers for the dual converter register front end.
 * assumes an 8-bit special-function register port of a processor core on core_clk.
 */
// Overview of operation
// - control bit 7 picks 8-bit mode when one, 12-bit mode when zero, both channels.
// - in 12-bit immediate mode a low-byte write refreshes that channel; write high first.
// - bit 6 ranges channel 1, bit 5 channel 0; one means supply, zero reference.
// - bit 4 clears channel 1, bit 3 channel 0; zero forces output to zero volts.
// - sync bit 2 set means each low-byte write updates that channel at once.
// - bit 1 powers channel 1, bit 0 channel 0; one is on, zero off.
// - control resets to 04h, both channels off with outputs high impedance.
// - 12-bit codes are right-justified: low byte eight lsbs, high nibble four msbs; 8-bit codes put the low byte in the eight msbs.
// - four data registers, low and high per channel, reset to 00h, set codes.
package ddrc_pkg;
    localparam logic [7:0] DDRC_ADDR_CH0_LOW = 8'hf9;
    localparam logic [7:0] DDRC_ADDR_CH0_HIGH = 8'hfa;
    localparam logic [7:0] DDRC_ADDR_CH1_LOW = 8'hfb;
    localparam logic [7:0] DDRC_ADDR_CH1_HIGH = 8'hfc;
    localparam logic [7:0] DDRC_ADDR_CONTROL = 8'hfd;
    localparam logic [7:0] DDRC_CONTROL_RESET = 8'h04;
    localparam logic [7:0] DDRC_DATA_RESET = 8'h00;
    localparam int DDRC_BIT_MODE8 = 7;
    localparam int DDRC_BIT_CH1_RANGE_SELECT = 6;
    localparam int DDRC_BIT_CH0_RANGE_SELECT = 5;
    localparam int DDRC_BIT_CH1_OUTPUT_CLEAR_N = 4;
    localparam int DDRC_BIT_CH0_OUTPUT_CLEAR_N = 3;
    localparam int DDRC_BIT_SYNC = 2;
    localparam int DDRC_BIT_PD1 = 1;
    localparam int DDRC_BIT_PD0 = 0;
    localparam int DDRC_CODE_W = 12;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ddrc_sfr_req_s;

    typedef struct packed {
        logic [DDRC_CODE_W-1:0] code;
        logic range_supply;
        logic power_on;
        logic output_enable;
    } ddrc_chan_out_s;
endpackage

// file: rtl/ddrc_code_form.sv
/*
 * forms one channel's new or pending code from its data bytes.
 * assumes byte registers held by the caller.
 */
`timescale 1ns/1ps
`default_nettype none
module ddrc_code_form (
    input wire logic mode8,
    input wire logic [7:0] data_low,
    input wire logic [7:0] data_high,
    output logic [ddrc_pkg::DDRC_CODE_W-1:0] code
);
    import ddrc_pkg::*;
    always_comb begin
        if (mode8) begin
            code = {data_low, 4'h0};
        end else begin
            code = {data_high[3:0], data_low};
        end
    end
endmodule
`default_nettype wire

// file: rtl/ddrc_chan_drive.sv
/*
 * per-channel output shaping: clear, power and range.
 * assumes the latched code comes from the update logic.
 */
`timescale 1ns/1ps
`default_nettype none
module ddrc_chan_drive (
    input wire logic [ddrc_pkg::DDRC_CODE_W-1:0] latched_code,
    input wire logic clear_n,
    input wire logic power_on,
    input wire logic range_supply,
    output var ddrc_pkg::ddrc_chan_out_s chan
);
    import ddrc_pkg::*;
    always_comb begin
        chan.code = clear_n ? latched_code : '0;
        chan.range_supply = range_supply;
        chan.power_on = power_on;
        chan.output_enable = power_on;
    end
endmodule
`default_nettype wire

// file: verification/ddrc_top_assertions.sv
/* port checker for ddrc_top.
   bound to every ddrc_top instance; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module ddrc_top_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire ddrc_pkg::ddrc_sfr_req_s sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire ddrc_pkg::ddrc_chan_out_s ch0_out,
    input wire ddrc_pkg::ddrc_chan_out_s ch1_out
);
    import ddrc_pkg::*;
    // ============================================================
    // shadow of the control register
    logic [7:0] ctl_q;
    logic w_ctl, w_l0, w_h0, w_l1;
    assign w_ctl = sfr_req.wr && sfr_req.addr == 8'hfd;
    assign w_l0 = sfr_req.wr && sfr_req.addr == 8'hf9;
    assign w_h0 = sfr_req.wr && sfr_req.addr == 8'hfa;
    assign w_l1 = sfr_req.wr && sfr_req.addr == 8'hfb;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctl_q <= DDRC_CONTROL_RESET;
        end else if (w_ctl) begin
            ctl_q <= sfr_req.wdata;
        end
    end
    // ============================================================
    // properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    hit_decode_a: assert property (sfr_hit == (sfr_req.addr inside {[8'hf9:8'hfd]}))
        else $error("hit decode wrong");
    oe_follows_power_a: assert property (ch0_out.output_enable == ch0_out.power_on
        && ch1_out.output_enable == ch1_out.power_on) else $error("enable not power");
    power_bits_a: assert property (w_ctl |=> ch1_out.power_on == $past(sfr_req.wdata[1])
        && ch0_out.power_on == $past(sfr_req.wdata[0])) else $error("power bits wrong");
    range_bits_a: assert property (w_ctl |=>
        {ch1_out.range_supply, ch0_out.range_supply} == $past(sfr_req.wdata[6:5]))
        else $error("range bits wrong");
    clear_zero_a: assert property (w_ctl && !sfr_req.wdata[3] |=> ch0_out.code == 12'h000)
        else $error("clear not zero");
    unmapped_read_a: assert property (sfr_req.rd && !sfr_hit |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    sync_hold_a: assert property (w_l0 && !ctl_q[2] |=> $stable(ch0_out.code))
        else $error("code moved with sync low");
    high_hold_a: assert property (w_h0 && ctl_q[2] |=> $stable(ch0_out.code))
        else $error("high byte moved code");
    low_update_a: assert property (w_l0 && ctl_q[2] && ctl_q[3] && !ctl_q[7] |=>
        ch0_out.code[7:0] == $past(sfr_req.wdata)) else $error("low write no update");
    mode8_code_a: assert property (w_l1 && ctl_q[2] && ctl_q[4] && ctl_q[7] |=>
        ch1_out.code == {$past(sfr_req.wdata), 4'h0}) else $error("8-bit code wrong");
endmodule
bind ddrc_top ddrc_top_checker chk_i (.core_clk(core_clk), .rst_n(rst_n), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .ch0_out(ch0_out), .ch1_out(ch1_out));
`default_nettype wire

// file: verification/tb_ddrc_top.sv
/* self-checking bench for ddrc_top.
   drives the sfr port at the falling edge; checker is bound separately. */
`timescale 1ns/1ps
`default_nettype none
module tb_ddrc_top;
    import ddrc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    ddrc_sfr_req_s req = '0;
    logic [7:0] rdata;
    logic hit;
    ddrc_chan_out_s c0, c1;
    int bad_count = 0;
    int n_compared = 0;
    always #12.5 core_clk = ~core_clk;
    ddrc_top uut (.core_clk(core_clk), .rst_n(rst_n), .sfr_req(req), .sfr_rdata(rdata),
        .sfr_hit(hit), .ch0_out(c0), .ch1_out(c1));
    // ============================================================
    // bus and compare tasks
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{1'b1, 1'b0, a, d};
        @(negedge core_clk);
        req = '0;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk);
        req = '0;
        chk({4'h0, rdata}, {4'h0, exp});
        @(negedge core_clk);
    endtask
    task automatic codes(input logic [11:0] e0, input logic [11:0] e1);
        chk(c0.code, e0);
        chk(c1.code, e1);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ============================================================
    // scenarios
    task automatic t_reset;
        rd(8'hfd, 8'h04);
        for (int i = 0; i < 4; i++) rd(8'hf9 + 8'(i), 8'h00);
        rd(8'hf8, 8'h00);
        chk({8'h0, c0.power_on, c0.output_enable, c1.power_on, c1.output_enable}, 12'h0);
        codes(12'h000, 12'h000);
        req.addr = 8'hfd;
        #1 chk({11'h0, hit}, 12'h001);
        req.addr = 8'hf8;
        #1 chk({11'h0, hit}, 12'h000);
        @(negedge core_clk);
        req = '0;
        @(negedge core_clk);
    endtask
    task automatic t_sync12;
        wr(8'hfd, 8'h3f);
        chk({8'h0, c1.range_supply, c0.range_supply, c1.power_on, c0.power_on}, 12'h7);
        wr(8'hfa, 8'h05);
        codes(12'h000, 12'h000);
        wr(8'hf9, 8'h23);
        codes(12'h523, 12'h000);
        rd(8'hfa, 8'h05);
    endtask
    task automatic t_sync0;
        wr(8'hfd, 8'h3b);
        wr(8'hfc, 8'h0a);
        wr(8'hfb, 8'hbc);
        wr(8'hfa, 8'h01);
        wr(8'hf9, 8'h02);
        codes(12'h523, 12'h000);
        wr(8'hfd, 8'h3f);
        codes(12'h102, 12'habc);
    endtask
    task automatic t_mode8;
        wr(8'hfd, 8'hbf);
        wr(8'hfa, 8'h0f);
        wr(8'hf9, 8'h5a);
        codes(12'h5a0, 12'habc);
        wr(8'hfb, 8'hc3);
        codes(12'h5a0, 12'hc30);
    endtask
    task automatic t_clear;
        wr(8'hfd, 8'hb7);
        codes(12'h000, 12'hc30);
        wr(8'hfd, 8'hb4);
        chk({8'h0, c0.power_on, c0.output_enable, c1.power_on, c1.output_enable}, 12'h0);
        wr(8'hf8, 8'hff);
        rd(8'hfd, 8'hb4);
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        t_reset;
        t_sync12;
        t_sync0;
        t_mode8;
        t_clear;
        tally_and_finish;
    end
    initial begin
        repeat (1000) @(posedge core_clk);
        bad_count++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
